//--- core/sps_i2c_writer.sv
/*
  Single I2C register write: start, address byte, register byte, data byte, stop.
  Assumes open-drain pins resolved outside; an enable high pulls the line low.
*/
`timescale 1ns/10ps
`default_nettype none
module sps_i2c_writer
  import sps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] wr_data,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic busy,
  output logic done,
  output logic nack,
  output logic scl_oe,
  output logic sda_oe
);
  typedef enum logic [3:0] {
    I2_IDLE = 4'b0001,
    I2_START = 4'b0010,
    I2_BITS = 4'b0100,
    I2_STOP = 4'b1000
  } sps_i2c_state_e;

  sps_i2c_state_e state;
  logic [7:0] qcnt;
  logic [1:0] phase;
  logic [4:0] bitn;
  logic [26:0] shreg;
  logic stretch;
  logic tick;

  // A slave holding SCL low while it is released stretches the high phase.
  assign stretch = (state == I2_BITS) && (phase == 2'd1 || phase == 2'd2) && !scl_in;
  assign tick = (qcnt == 8'(I2C_QUARTER_CYCLES - 1)) && !stretch;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qcnt <= 8'h00;
    end else if (state == I2_IDLE || tick) begin
      qcnt <= 8'h00;
    end else if (!stretch) begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= I2_IDLE;
      phase <= 2'd0;
      bitn <= 5'd0;
      shreg <= 27'h000_0000;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        I2_IDLE: begin
          if (start) begin
            shreg <= {dev_addr, 1'b0, 1'b1, reg_addr, 1'b1, wr_data, 1'b1};
            nack <= 1'b0;
            busy <= 1'b1;
            sda_oe <= 1'b1;
            phase <= 2'd0;
            state <= I2_START;
          end
        end
        I2_START: begin
          if (tick) begin
            if (phase == 2'd0) begin
              scl_oe <= 1'b1;
              phase <= 2'd1;
            end else begin
              sda_oe <= ~shreg[26];
              bitn <= 5'd0;
              phase <= 2'd0;
              state <= I2_BITS;
            end
          end
        end
        I2_BITS: begin
          if (tick) begin
            phase <= phase + 2'd1;
            case (phase)
              2'd0: begin
                scl_oe <= 1'b0;
              end
              2'd1: begin
                if ((bitn == 5'd8 || bitn == 5'd17 || bitn == 5'd26) && sda_in) begin
                  nack <= 1'b1;
                end
              end
              2'd2: begin
                scl_oe <= 1'b1;
              end
              default: begin
                if (bitn == 5'd26) begin
                  sda_oe <= 1'b1;
                  state <= I2_STOP;
                end else begin
                  bitn <= bitn + 5'd1;
                  shreg <= {shreg[25:0], 1'b0};
                  sda_oe <= ~shreg[25];
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            phase <= phase + 2'd1;
            if (phase == 2'd0) begin
              scl_oe <= 1'b0;
            end else if (phase == 2'd1) begin
              sda_oe <= 1'b0;
            end else begin
              busy <= 1'b0;
              done <= 1'b1;
              phase <= 2'd0;
              state <= I2_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule : sps_i2c_writer
`default_nettype wire

//--- core/sps_init_sequencer.sv
/*
  Host-side power-up and PLL initialisation sequencer for a video serializer.
  Assumes supply-good, pixel-clock-stable and PLL-lock levels synchronous to CLK_SYS,
  an open-drain I2C bus to the serializer, and software on an APB port.
*/
// Decided for this implementation: the APB interface to the registers.
// Overview of operation
// - Keep release pin low until the pixel clock is stable, then release.
// - If pixel clock drops before writes begin, pulse the pin low again.
// - Early release allowed; PLL sequence then waits for a stable pixel clock.
// - PLL loop-filter and reset writes first, divider reset burst afterwards.
// - No register access until 2 ms after the pin goes high.
// - A hard reset holds the pin low for at least 2 ms.
// - Pixel clock stable for 1 us before release or PLL reset writes.
// - The pin is active high and driven by this logic directly.
// - Release only after supplies are good, with zero added delay.
// - Software supplies the measured ambient temperature before starting.
// - Input PLL page 0x10, then counter depth 0x4A gets 0x3F.
// - Standard variant: setting 0x4B gets 0x88 below 10 C, else 0x89.
// - Offset 0x49 then 0x10 and 0x00 pulse the PLL state reset.
// - Output PLL page 0x14 repeats depth, loop filter and reset steps.
// - Extended input PLL: 0x88 below -10 C, 0x89 below 60, else 0x8A.
// - Extended output PLL: 0x89 below -10 C, 0x8A below 60, else 0x8B.
// - Every start pulses reset and reruns the full programming; the code takes a start only in idle, done or fail.
// - Optionally defer input PLL reset to just before output PLL reset.
// - Divider reset: page 0x10, 0x49, 0x16, four 0x20, seven 0x00.
// - Divider reset only after input PLL lock and only for dual input.
`timescale 1ns/10ps
`default_nettype none
module sps_init_sequencer
  import sps_pkg::*;
#(
  parameter int unsigned HARD_RESET_CYC = HARD_RESET_CYCLES,
  parameter int unsigned I2C_READY_CYC = I2C_READY_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SUPPLY_GOOD,
  input wire logic PCLK_STABLE,
  input wire logic INPUT_PLL_LOCK,
  output logic POWER_DOWN_RELEASE_PIN,
  input wire logic I2C_SCL_I,
  output logic I2C_SCL_O,
  output logic I2C_SCL_OE,
  input wire logic I2C_SDA_I,
  output logic I2C_SDA_O,
  output logic I2C_SDA_OE
);
  sps_state_e state;
  logic [4:0] ctrl;
  logic [7:0] temp;
  logic [6:0] dev_addr;
  logic [23:0] cnt;
  logic [5:0] stable_cnt;
  logic clk_ok;
  logic [4:0] idx;
  logic pend;
  logic wr_start;
  logic nack_seen;
  logic [7:0] lf_in;
  logic [7:0] lf_out;
  logic start_req;
  logic apb_wr;
  logic [16:0] pll_item;
  logic [16:0] div_item;
  logic [16:0] cur_item;
  logic i2c_done;
  logic i2c_nack;

  // ----------------------------------------------------------------------------
  // Write lists: {valid, register offset, data}
  // ----------------------------------------------------------------------------
  function automatic logic [16:0] pll_block(input logic [2:0] j, input logic [7:0] page,
                                             input logic [7:0] lf);
    logic [16:0] r;
    r = 17'h0_0000;
    case (j)
      3'd0: r = {1'b1, REG_INDIRECT_PAGE_SELECT, page};
      3'd1: r = {1'b1, REG_INDIRECT_OFFSET, IND_PPM_COUNTER};
      3'd2: r = {1'b1, REG_INDIRECT_DATA, PPM_DEPTH_14BIT};
      3'd3: r = {1'b1, REG_INDIRECT_OFFSET, IND_PLL_SETTING};
      3'd4: r = {1'b1, REG_INDIRECT_DATA, lf};
      3'd5: r = {1'b1, REG_INDIRECT_OFFSET, IND_PLL_STATE_CTL};
      3'd6: r = {1'b1, REG_INDIRECT_DATA, STATE_RESET_ON};
      default: r = {1'b1, REG_INDIRECT_DATA, STATE_RESET_OFF};
    endcase
    return r;
  endfunction : pll_block

  function automatic logic [16:0] pll_step(input logic [4:0] i, input logic defer,
                                            input logic [7:0] lfi, input logic [7:0] lfo);
    logic [16:0] r;
    r = 17'h0_0000;
    if (!defer) begin
      if (i < 5'd8) begin
        r = pll_block(i[2:0], PAGE_INPUT_PLL, lfi);
      end else if (i < 5'd16) begin
        r = pll_block(i[2:0], PAGE_OUTPUT_PLL, lfo);
      end
    end else begin
      // Input reset moved next to the output reset, so the link drops once.
      if (i < 5'd5) begin
        r = pll_block(i[2:0], PAGE_INPUT_PLL, lfi);
      end else if (i < 5'd10) begin
        r = pll_block(3'(i - 5'd5), PAGE_OUTPUT_PLL, lfo);
      end else if (i < 5'd14) begin
        r = (i == 5'd10) ? pll_block(3'd0, PAGE_INPUT_PLL, lfi) :
            pll_block(3'(i - 5'd6), PAGE_INPUT_PLL, lfi);
      end else if (i < 5'd18) begin
        r = (i == 5'd14) ? pll_block(3'd0, PAGE_OUTPUT_PLL, lfo) :
            pll_block(3'(i - 5'd10), PAGE_OUTPUT_PLL, lfo);
      end
    end
    return r;
  endfunction : pll_step

  always_comb begin
    div_item = 17'h0_0000;
    if (idx == 5'd0) begin
      div_item = {1'b1, REG_INDIRECT_PAGE_SELECT, PAGE_INPUT_PLL};
    end else if (idx == 5'd1) begin
      div_item = {1'b1, REG_INDIRECT_OFFSET, IND_PLL_STATE_CTL};
    end else if (idx == 5'd2) begin
      div_item = {1'b1, REG_INDIRECT_DATA, DIV_RESET_ARM};
    end else if (idx < 5'd7) begin
      div_item = {1'b1, REG_INDIRECT_DATA, DIV_RESET_PULSE};
    end else if (idx < 5'd14) begin
      div_item = {1'b1, REG_INDIRECT_DATA, STATE_RESET_OFF};
    end
  end

  assign pll_item = pll_step(idx, ctrl[CTRL_DEFER_RESET_BIT], lf_in, lf_out);
  assign cur_item = (state == ST_DIV_WR) ? div_item : pll_item;

  // ----------------------------------------------------------------------------
  // Loop-filter choice from the ambient temperature
  // ----------------------------------------------------------------------------
  always_comb begin
    if (!ctrl[CTRL_EXTENDED_BIT]) begin
      lf_in = ($signed(temp) < TEMP_STD_SPLIT) ? LOOP_FILTER_88 : LOOP_FILTER_89;
      lf_out = lf_in;
    end else if ($signed(temp) < TEMP_EXT_LOW) begin
      lf_in = LOOP_FILTER_88;
      lf_out = LOOP_FILTER_89;
    end else if ($signed(temp) < TEMP_EXT_HIGH) begin
      lf_in = LOOP_FILTER_89;
      lf_out = LOOP_FILTER_8A;
    end else begin
      lf_in = LOOP_FILTER_8A;
      lf_out = LOOP_FILTER_8B;
    end
  end

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      if (PSEL && !PENABLE) begin
        if (PADDR == APB_CTRL) begin
          PRDATA <= {27'h000_0000, ctrl[4:1], 1'b0};
        end else if (PADDR == APB_TEMP) begin
          PRDATA <= {24'h00_0000, temp};
        end else if (PADDR == APB_STATUS) begin
          PRDATA <= {6'h00, state, 12'h000, nack_seen, POWER_DOWN_RELEASE_PIN,
                     state == ST_DONE, !(state == ST_IDLE || state == ST_DONE
                     || state == ST_FAIL)};
        end else if (PADDR == APB_DEV_ADDR) begin
          PRDATA <= {25'h000_0000, dev_addr};
        end else begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
      temp <= TEMP_RESET;
      dev_addr <= DEV_ADDR_RESET;
      start_req <= 1'b0;
    end else begin
      start_req <= apb_wr && PADDR == APB_CTRL && PWDATA[CTRL_START_BIT];
      if (apb_wr && PADDR == APB_CTRL && (state == ST_IDLE || state == ST_DONE
          || state == ST_FAIL)) begin
        ctrl <= {PWDATA[4:1], 1'b0};
      end else if (apb_wr && PADDR == APB_TEMP) begin
        temp <= PWDATA[7:0];
      end else if (apb_wr && PADDR == APB_DEV_ADDR) begin
        dev_addr <= PWDATA[6:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pixel clock stability
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      stable_cnt <= 6'd0;
    end else if (!PCLK_STABLE) begin
      stable_cnt <= 6'd0;
    end else if (!clk_ok) begin
      stable_cnt <= stable_cnt + 6'd1;
    end
  end

  assign clk_ok = stable_cnt >= 6'(CLOCK_STABLE_CYCLES);

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      POWER_DOWN_RELEASE_PIN <= 1'b0;
      cnt <= 24'h00_0000;
      idx <= 5'd0;
      pend <= 1'b0;
      wr_start <= 1'b0;
      nack_seen <= 1'b0;
    end else begin
      wr_start <= 1'b0;
      cnt <= cnt + 24'h00_0001;
      case (state)
        ST_IDLE, ST_DONE, ST_FAIL: begin
          if (start_req) begin
            POWER_DOWN_RELEASE_PIN <= 1'b0;
            nack_seen <= 1'b0;
            cnt <= 24'h00_0000;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt >= 24'(HARD_RESET_CYC - 1)) begin
            cnt <= 24'h00_0000;
            state <= ST_WAIT_SUPPLY;
          end
        end
        ST_WAIT_SUPPLY: begin
          if (!SUPPLY_GOOD) begin
            cnt <= 24'h00_0000;
          end else if (cnt >= 24'(SUPPLY_CYCLES - 1)) begin
            cnt <= 24'h00_0000;
            if (ctrl[CTRL_EARLY_RELEASE_BIT]) begin
              POWER_DOWN_RELEASE_PIN <= 1'b1;
              state <= ST_I2C_WAIT;
            end else begin
              state <= ST_WAIT_CLK;
            end
          end
        end
        ST_WAIT_CLK: begin
          cnt <= 24'h00_0000;
          if (clk_ok && SUPPLY_GOOD) begin
            POWER_DOWN_RELEASE_PIN <= 1'b1;
            state <= ST_I2C_WAIT;
          end
        end
        ST_I2C_WAIT: begin
          if (!PCLK_STABLE && !ctrl[CTRL_EARLY_RELEASE_BIT]) begin
            POWER_DOWN_RELEASE_PIN <= 1'b0;
            cnt <= 24'h00_0000;
            state <= ST_HOLD;
          end else if (cnt >= 24'(I2C_READY_CYC - 1) && clk_ok) begin
            idx <= 5'd0;
            state <= ST_PLL_WR;
          end
        end
        ST_PLL_WR, ST_DIV_WR: begin
          if (!pend) begin
            if (cur_item[16]) begin
              wr_start <= 1'b1;
              pend <= 1'b1;
            end else if (state == ST_PLL_WR && ctrl[CTRL_DUAL_PORT_BIT]) begin
              state <= ST_WAIT_LOCK;
            end else begin
              state <= ST_DONE;
            end
          end else if (i2c_done) begin
            pend <= 1'b0;
            idx <= idx + 5'd1;
            if (i2c_nack) begin
              nack_seen <= 1'b1;
              state <= ST_FAIL;
            end
          end
        end
        ST_WAIT_LOCK: begin
          idx <= 5'd0;
          if (INPUT_PLL_LOCK) begin
            state <= ST_DIV_WR;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // I2C engine and pins
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      I2C_SCL_O <= 1'b0;
      I2C_SDA_O <= 1'b0;
    end else begin
      I2C_SCL_O <= 1'b0;
      I2C_SDA_O <= 1'b0;
    end
  end

  sps_i2c_writer u_i2c (
    .clk(CLK_SYS),
    .rst(RST),
    .start(wr_start),
    .dev_addr(dev_addr),
    .reg_addr(cur_item[15:8]),
    .wr_data(cur_item[7:0]),
    .scl_in(I2C_SCL_I),
    .sda_in(I2C_SDA_I),
    .busy(),
    .done(i2c_done),
    .nack(i2c_nack),
    .scl_oe(I2C_SCL_OE),
    .sda_oe(I2C_SDA_OE)
  );
endmodule : sps_init_sequencer
`default_nettype wire

//--- pkg/sps_pkg.sv
/*
  Constants, register map and state encoding for the serializer PLL initialisation sequencer.
  Assumes a 50 MHz system clock and a serializer reached over I2C through its indirect window.
*/
package sps_pkg;
  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned I2C_READY_DELAY_MS = 2;
  localparam int unsigned HARD_RESET_PULSE_WIDTH_MS = 2;
  localparam int unsigned CLOCK_STABLE_TO_RESET_DELAY_US = 1;
  localparam int unsigned SUPPLY_TO_RELEASE_DELAY_MS = 0;
  localparam int unsigned I2C_READY_CYCLES = I2C_READY_DELAY_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned HARD_RESET_CYCLES = HARD_RESET_PULSE_WIDTH_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned CLOCK_STABLE_CYCLES =
    (CLOCK_STABLE_TO_RESET_DELAY_US * CLK_FREQ_HZ + 999_999) / 1_000_000;
  localparam int unsigned SUPPLY_RAW_CYCLES = SUPPLY_TO_RELEASE_DELAY_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned SUPPLY_CYCLES = (SUPPLY_RAW_CYCLES == 0) ? 1 : SUPPLY_RAW_CYCLES;
  localparam int unsigned I2C_BUS_HZ = 960_000;
  localparam int unsigned I2C_QUARTER_CYCLES = CLK_FREQ_HZ / (4 * I2C_BUS_HZ);
  // ----------------------------------------------------------------------------
  // Serializer registers and values
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_INDIRECT_PAGE_SELECT = 8'h40;
  localparam logic [7:0] REG_INDIRECT_OFFSET = 8'h41;
  localparam logic [7:0] REG_INDIRECT_DATA = 8'h42;
  localparam logic [7:0] PAGE_INPUT_PLL = 8'h10;
  localparam logic [7:0] PAGE_OUTPUT_PLL = 8'h14;
  localparam logic [7:0] IND_PLL_STATE_CTL = 8'h49;
  localparam logic [7:0] IND_PPM_COUNTER = 8'h4A;
  localparam logic [7:0] IND_PLL_SETTING = 8'h4B;
  localparam logic [7:0] PPM_DEPTH_14BIT = 8'h3F;
  localparam logic [7:0] LOOP_FILTER_88 = 8'h88;
  localparam logic [7:0] LOOP_FILTER_89 = 8'h89;
  localparam logic [7:0] LOOP_FILTER_8A = 8'h8A;
  localparam logic [7:0] LOOP_FILTER_8B = 8'h8B;
  localparam logic [7:0] STATE_RESET_ON = 8'h10;
  localparam logic [7:0] STATE_RESET_OFF = 8'h00;
  localparam logic [7:0] DIV_RESET_ARM = 8'h16;
  localparam logic [7:0] DIV_RESET_PULSE = 8'h20;
  localparam logic signed [7:0] TEMP_STD_SPLIT = 8'sd10;
  localparam logic signed [7:0] TEMP_EXT_LOW = -8'sd10;
  localparam logic signed [7:0] TEMP_EXT_HIGH = 8'sd60;
  // ----------------------------------------------------------------------------
  // Controller registers on APB
  // ----------------------------------------------------------------------------
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_TEMP = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_DEV_ADDR = 8'h0C;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_EXTENDED_BIT = 1;
  localparam int unsigned CTRL_DUAL_PORT_BIT = 2;
  localparam int unsigned CTRL_EARLY_RELEASE_BIT = 3;
  localparam int unsigned CTRL_DEFER_RESET_BIT = 4;
  localparam int unsigned STATUS_STATE_POS = 16;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  // Arbitrary neutral default for the serializer's I2C address.
  localparam logic [6:0] DEV_ADDR_RESET = 7'h2A;
  // ----------------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_HOLD = 10'b00_0000_0010,
    ST_WAIT_SUPPLY = 10'b00_0000_0100,
    ST_WAIT_CLK = 10'b00_0000_1000,
    ST_I2C_WAIT = 10'b00_0001_0000,
    ST_PLL_WR = 10'b00_0010_0000,
    ST_WAIT_LOCK = 10'b00_0100_0000,
    ST_DIV_WR = 10'b00_1000_0000,
    ST_DONE = 10'b01_0000_0000,
    ST_FAIL = 10'b10_0000_0000
  } sps_state_e;
endpackage : sps_pkg

//--- test/sps_init_sequencer_monitor.sv
/* Checker on the sequencer's top ports.
   Assumes the bind below hands on the count parameters. */
`timescale 1ns/10ps
`default_nettype none
module sps_init_sequencer_monitor
  import sps_pkg::*;
#(
  parameter int unsigned HARD_RESET_CYC = 20,
  parameter int unsigned I2C_READY_CYC = 20
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SUPPLY_GOOD,
  input wire logic PCLK_STABLE,
  input wire logic POWER_DOWN_RELEASE_PIN,
  input wire logic I2C_SCL_I,
  input wire logic I2C_SDA_OE
);
  int unsigned lo, hi, st;
  wire logic pin = POWER_DOWN_RELEASE_PIN;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      {lo, hi, st} <= 0;
    end else begin
      lo <= pin ? 0 : lo + 1;
      hi <= pin ? hi + 1 : 0;
      st <= PCLK_STABLE ? st + 1 : 0;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  pin_low_a: assert property ($rose(pin) |-> lo >= HARD_RESET_CYC)
    else $error("reset pulse short");
  low_hold_a: assert property ($fell(pin) |-> !pin [*8])
    else $error("reset pulse cut");
  ready_wait_a: assert property ($rose(I2C_SDA_OE) |-> pin && hi >= I2C_READY_CYC)
    else $error("bus used early");
  supply_first_a: assert property ($rose(pin) |-> SUPPLY_GOOD && $past(SUPPLY_GOOD))
    else $error("release before supply");
  clock_first_a:
    assert property ($rose(I2C_SDA_OE) && I2C_SCL_I |-> st >= CLOCK_STABLE_CYCLES)
    else $error("write on unstable clock");
  ready_next_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready");
  ready_once_a: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  unmapped_a: assert property (PSEL && !PENABLE && PADDR > APB_DEV_ADDR |=> PSLVERR)
    else $error("no slave error");
  cover property ($rose(pin));
  cover property ($rose(I2C_SDA_OE) && I2C_SCL_I);
  cover property (PSLVERR);
endmodule : sps_init_sequencer_monitor
bind sps_init_sequencer sps_init_sequencer_monitor #(.HARD_RESET_CYC(HARD_RESET_CYC),
  .I2C_READY_CYC(I2C_READY_CYC)) mon (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SUPPLY_GOOD(SUPPLY_GOOD), .PCLK_STABLE(PCLK_STABLE), .I2C_SCL_I(I2C_SCL_I),
  .POWER_DOWN_RELEASE_PIN(POWER_DOWN_RELEASE_PIN), .I2C_SDA_OE(I2C_SDA_OE));
`default_nettype wire

//--- test/sps_serializer_model.sv
/* Serializer model on I2C: indirect window, logging each analog write.
   Assumes the bench resolves both lines as pulled low by any pull enable. */
`timescale 1ns/10ps
`default_nettype none
module sps_serializer_model
  import sps_pkg::*;
#(
  parameter int unsigned READY_CYC = 20
) (
  input wire logic clk,
  input wire logic pin,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] stretch,
  output logic scl_oe,
  output logic sda_oe
);
  logic [7:0] page, offs, sh;
  logic [7:0] b [3];
  logic [23:0] log_q [$];
  int nb = 0, nby = 0, up = 0;
  initial scl_oe = 0;
  initial sda_oe = 0;
  always @(posedge clk) begin
    up = pin ? up + 1 : 0;
    if (!pin) begin
      {page, offs, sda_oe} = 17'h0_0000;
      {nb, nby} = 0;
    end
  end
  always @(negedge sda) if (scl === 1'b1) {nb, nby} = 0;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    nb++;
  end
  always @(negedge scl) begin
    if (nb == 8 && nby < 3) begin
      b[nby] = sh;
      sda_oe = up >= READY_CYC && (nby > 0 || sh == {DEV_ADDR_RESET, 1'b0});
    end else if (nb == 9) begin
      sda_oe = 0;
      nb = 0;
      nby++;
    end
  end
  always @(negedge scl) if (stretch != 0) begin
    scl_oe = 1;
    repeat (stretch) @(posedge clk);
    scl_oe = 0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    if (nby == 3 && b[1] == REG_INDIRECT_PAGE_SELECT) page = b[2];
    if (nby == 3 && b[1] == REG_INDIRECT_OFFSET) offs = b[2];
    if (nby == 3 && b[1] == REG_INDIRECT_DATA && page[4:3] == 2'b10 && !page[0])
      log_q.push_back({page, offs, b[2]});
    {nb, nby} = 0;
  end
endmodule : sps_serializer_model
`default_nettype wire

//--- test/test_sps_init_sequencer.sv
/* Bench: APB tasks drive the sequencer, a serializer model logs its writes.
   Assumes hold and ready counts shortened to 20 cycles. */
`timescale 1ns/10ps
`default_nettype none
module test_sps_init_sequencer
  import sps_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sup = 0, pst = 0, lock = 0, e;
  logic [7:0] padr = 8'h00, str = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, prd, q;
  logic prdy, perr, pin, d_scl, d_sda, m_scl, m_sda, so, sd;
  logic [23:0] xq [$];
  int n_errors = 0, comparisons = 0;
  wire logic scl = ~(d_scl | m_scl);
  wire logic sda = ~(d_sda | m_sda);
  always #10 clk = ~clk;
  sps_init_sequencer #(.HARD_RESET_CYC(20), .I2C_READY_CYC(20)) uut (.CLK_SYS(clk), .RST(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .SUPPLY_GOOD(sup), .PCLK_STABLE(pst), .INPUT_PLL_LOCK(lock),
    .POWER_DOWN_RELEASE_PIN(pin), .I2C_SCL_I(scl), .I2C_SCL_O(so), .I2C_SCL_OE(d_scl),
    .I2C_SDA_I(sda), .I2C_SDA_O(sd), .I2C_SDA_OE(d_sda));
  sps_serializer_model mdl (.clk(clk), .pin(pin), .scl(scl), .sda(sda), .stretch(str),
    .scl_oe(m_scl), .sda_oe(m_sda));
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", s, x, g);
      n_errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    {psel, pen, pwr, padr, pwd} <= {2'b10, w, a, dt};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    {q, e} = {prd, perr};
    {psel, pen} <= 2'b00;
  endtask : apb
  task automatic pl(input logic [7:0] p, input logic [7:0] lf, input logic [1:0] m);
    if (m[1]) xq.push_back({p, IND_PPM_COUNTER, PPM_DEPTH_14BIT});
    if (m[1]) xq.push_back({p, IND_PLL_SETTING, lf});
    if (m[0]) xq.push_back({p, IND_PLL_STATE_CTL, STATE_RESET_ON});
    if (m[0]) xq.push_back({p, IND_PLL_STATE_CTL, STATE_RESET_OFF});
  endtask : pl
  task automatic go(input logic [7:0] t, input logic [31:0] c);
    xq.delete();
    mdl.log_q.delete();
    apb(1, APB_TEMP, 32'(t));
    apb(0, APB_TEMP, 0);
    chk("temp", 32'(t), q);
    apb(1, APB_CTRL, c);
  endtask : go
  task automatic fin(input string s);
    do begin
      repeat (500) @(posedge clk);
      apb(0, APB_STATUS, 0);
    end while (q[1] !== 1'b1 && q[25] !== 1'b1);
    chk("count", 32'(xq.size()), 32'(mdl.log_q.size()));
    foreach (xq[i]) chk("write", 32'(xq[i]), 32'(mdl.log_q[i]));
    $display("test %s done", s);
  endtask : fin
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    repeat (95_000) @(posedge clk);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    apb(0, APB_DEV_ADDR, 0);
    chk("address", 32'h0000_002A, q);
    apb(0, 8'h10, 0);
    chk("unmapped", 32'h0000_0001, {q[30:0], e});
    apb(0, APB_STATUS, 0);
    chk("status", 32'h0001_0000, q);
    go(8'h09, 32'h0000_0001);
    repeat (100) @(posedge clk);
    chk("held", 0, 32'(pin));
    {sup, pst} <= 2'b11;
    @(posedge pin);
    repeat (5) @(posedge clk);
    pst <= 0;
    repeat (4) @(posedge clk);
    chk("retoggle", 0, 32'(pin));
    pst <= 1;
    pl(PAGE_INPUT_PLL, LOOP_FILTER_88, 2'b11);
    pl(PAGE_OUTPUT_PLL, LOOP_FILTER_88, 2'b11);
    fin("standard");
    {pst, str} <= 9'h003;
    go(8'h3C, 32'h0000_001F);
    @(posedge pin);
    repeat (100) @(posedge clk);
    chk("early", 1, 32'(pin));
    pst <= 1;
    while (mdl.log_q.size() < 8) @(posedge clk);
    repeat (2000) @(posedge clk);
    chk("lock", 8, 32'(mdl.log_q.size()));
    lock <= 1;
    pl(PAGE_INPUT_PLL, LOOP_FILTER_8A, 2'b10);
    pl(PAGE_OUTPUT_PLL, LOOP_FILTER_8B, 2'b10);
    pl(PAGE_INPUT_PLL, 0, 2'b01);
    pl(PAGE_OUTPUT_PLL, 0, 2'b01);
    xq.push_back({PAGE_INPUT_PLL, IND_PLL_STATE_CTL, DIV_RESET_ARM});
    repeat (4) xq.push_back({PAGE_INPUT_PLL, IND_PLL_STATE_CTL, DIV_RESET_PULSE});
    repeat (7) xq.push_back({PAGE_INPUT_PLL, IND_PLL_STATE_CTL, STATE_RESET_OFF});
    fin("extended");
    apb(1, APB_DEV_ADDR, 32'h0000_002B);
    go(8'h09, 32'h0000_0001);
    fin("refused");
    chk("fail", 32'h0200_0008, q & 32'h0200_0008);
    chk("drive", 0, {so, sd});
    test_done();
  end
endmodule : test_sps_init_sequencer
`default_nettype wire
